// [hw/rms_power_calc.sv]
// What this block does
// - Each RMS is square, low-pass filter, then square root.
// - RMS smoothing filter suppresses 50/60 Hz harmonics by at least 64 dB.
// - All eight RMS results refresh once per 8 ksps sample.
// - RMS result bandwidth is 3.2 kHz.
// - Full-scale input gives RMS 52,702,092; full scale shrinks with amplifier gain.
// - Result is root of (raw RMS squared plus offset trim times 2^15).
// - Neutral RMS has own result and offset trim, phase-current scaling.
// - Current-sum RMS uses same method, scaling and its own offset trim.
// - Sum code 00/11 phases only, 01 adds neutral, 10 subtracts neutral.
// - Mismatch flag sets when sum RMS versus threshold relation changes.
// - Active power is I times V, filtered unless filter-disable bit is 1.
// - Power gain trim applied after filtering, then power offset added.
// - Active power refreshes at 8 ksps with 3.2 kHz bandwidth.
// - Full-scale inputs with no gain trim give active power 20,694,066.
// - 50 Hz RMS settles to 99 percent within 0.48 s.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rms_power_calc (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Waveform samples from the decimation chain
    input wire logic sample_valid,
    input wire rms_power_pkg::samples_t samples,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Mismatch interrupt
    output logic mismatch_irq
);

    // ****************************************
    // State
    // ****************************************
    rms_power_pkg::state_t state_ff;
    rms_power_pkg::samples_t smp_ff;
    rms_power_pkg::cfg_t cfg_ff;
    logic [3:0] ch_ff;
    logic [4:0] step_ff;
    logic signed [63:0] prod_ff;
    logic signed [63:0] y1_ff;
    logic signed [63:0] filt_ff;
    logic [63:0] rad_ff;
    logic [63:0] rad_in_ff;
    logic [34:0] rem_ff;
    logic [31:0] root_ff;
    logic [31:0] rms_ff [8];
    logic [31:0] watt_ff [3];
    logic [31:0] rmsos_ff [8];
    logic [31:0] pgain_ff [3];
    logic [31:0] wattos_ff [3];
    logic [31:0] thr_ff;
    logic mismatch_ff;
    logic above_ff;

    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] n);
        in_win = (a >= base) && (a < base + {n[5:0], 2'h0});
    endfunction

    // ****************************************
    // Operand selection
    // ****************************************
    wire logic is_pwr = (ch_ff >= rms_power_pkg::CH_FIRST_PWR);
    wire logic [1:0] pidx = 2'(ch_ff - rms_power_pkg::CH_FIRST_PWR);
    wire logic [1:0] vidx = 2'(ch_ff - 4'h4);
    wire logic signed [34:0] ia = 35'($signed(smp_ff.cur[0]));
    wire logic signed [34:0] ib = 35'($signed(smp_ff.cur[1]));
    wire logic signed [34:0] ic = 35'($signed(smp_ff.cur[2]));
    wire logic signed [34:0] in_n = 35'($signed(smp_ff.neu));
    wire logic signed [34:0] isum_ph = ia + ib + ic;
    wire logic signed [34:0] isum_w = (cfg_ff.isum_cfg == rms_power_pkg::ISUM_ADD_N) ?
        isum_ph + in_n : (cfg_ff.isum_cfg == rms_power_pkg::ISUM_SUB_N) ?
        isum_ph - in_n : isum_ph;
    logic signed [34:0] op_a;
    logic signed [34:0] op_b;

    always_comb
    begin
        op_a = '0;
        op_b = '0;
        if (is_pwr)
        begin
            op_a = 35'($signed(smp_ff.cur[pidx]));
            op_b = 35'($signed(smp_ff.volt[pidx]));
        end
        else if (ch_ff < 4'h3)
        begin
            op_a = 35'($signed(smp_ff.cur[ch_ff[1:0]]));
            op_b = op_a;
        end
        else if (ch_ff == 4'h3)
        begin
            op_a = in_n;
            op_b = in_n;
        end
        else if (ch_ff < rms_power_pkg::CH_ISUM)
        begin
            op_a = 35'($signed(smp_ff.volt[vidx]));
            op_b = op_a;
        end
        else
        begin
            op_a = isum_w;
            op_b = isum_w;
        end
    end

    // Squaring for RMS channels, I times V for power channels
    wire logic signed [63:0] prod_w = 64'(op_a) * 64'(op_b);

    // ****************************************
    // Two cascaded first-order sections
    // ****************************************
    // Shift 9 twice gives about 64 dB at 100 Hz and settles in about 0.42 s at
    // 8 ksps; a single section would need a far slower corner to match it.
    wire logic [63:0] mem_rd;
    wire logic signed [63:0] old_w = $signed(mem_rd);
    wire logic signed [63:0] y1_new = old_w + ((prod_ff - old_w) >>> rms_power_pkg::FILT_SHIFT);
    wire logic signed [63:0] y2_new = old_w + ((y1_ff - old_w) >>> rms_power_pkg::FILT_SHIFT);
    wire logic bypass = is_pwr && cfg_ff.power_filter_disable;
    wire logic signed [63:0] filt_w = bypass ? prod_ff : y2_new;
    wire logic signed [63:0] os_ext = 64'($signed(rmsos_ff[ch_ff[2:0]]));
    wire logic signed [63:0] rad_sum = y2_new + (os_ext <<< rms_power_pkg::OFFS_SHIFT);
    wire logic [63:0] rad_w = rad_sum[63] ? 64'h0 : rad_sum;

    rms_state_mem u_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en((state_ff == rms_power_pkg::ST_FILT1) || (state_ff == rms_power_pkg::ST_FILT2)),
        .wr_addr({state_ff == rms_power_pkg::ST_FILT2, ch_ff}),
        .wr_data((state_ff == rms_power_pkg::ST_FILT2) ? y2_new : y1_new),
        .rd_addr({state_ff == rms_power_pkg::ST_FILT1, ch_ff}),
        .rd_data(mem_rd)
    );

    // ****************************************
    // Bit-serial square root, one result bit per cycle
    // ****************************************
    wire logic [34:0] cand = {rem_ff[32:0], rad_ff[63:62]};
    wire logic [34:0] trial = cand - {1'h0, root_ff, 2'h1};
    wire logic fits = !trial[34];

    // ****************************************
    // Power scaling: full-scale mean product over 2^27 lands at 20,694,066
    // ****************************************
    wire logic signed [63:0] pw = filt_ff >>> rms_power_pkg::WATT_SHIFT;
    wire logic signed [63:0] gterm = (pw * 64'($signed(pgain_ff[pidx])))
        >>> rms_power_pkg::GAIN_SHIFT;
    wire logic signed [63:0] watt_w = pw + gterm + 64'($signed(wattos_ff[pidx]));
    wire logic above_w = root_ff > thr_ff;
    wire logic mm_event = (state_ff == rms_power_pkg::ST_STORE) &&
        (ch_ff == rms_power_pkg::CH_ISUM) && (above_w != above_ff);

    // ****************************************
    // Sequencer: one pass over eleven channels per sample
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= rms_power_pkg::ST_IDLE;
            ch_ff <= '0;
            step_ff <= '0;
            smp_ff <= '0;
            prod_ff <= '0;
            y1_ff <= '0;
            filt_ff <= '0;
            rad_ff <= '0;
            rad_in_ff <= '0;
            rem_ff <= '0;
            root_ff <= '0;
        end
        else
        begin
            case (state_ff)
                rms_power_pkg::ST_IDLE:
                begin
                    if (sample_valid)
                    begin
                        smp_ff <= samples;
                        ch_ff <= '0;
                        state_ff <= rms_power_pkg::ST_LOAD;
                    end
                end
                rms_power_pkg::ST_LOAD:
                begin
                    prod_ff <= prod_w;
                    state_ff <= rms_power_pkg::ST_FILT1;
                end
                rms_power_pkg::ST_FILT1:
                begin
                    y1_ff <= y1_new;
                    state_ff <= rms_power_pkg::ST_FILT2;
                end
                rms_power_pkg::ST_FILT2:
                begin
                    filt_ff <= filt_w;
                    rad_ff <= rad_w;
                    rad_in_ff <= rad_w;
                    rem_ff <= '0;
                    root_ff <= '0;
                    step_ff <= '0;
                    state_ff <= is_pwr ? rms_power_pkg::ST_STORE : rms_power_pkg::ST_ROOT;
                end
                rms_power_pkg::ST_ROOT:
                begin
                    rem_ff <= fits ? trial : cand;
                    root_ff <= {root_ff[30:0], fits};
                    rad_ff <= {rad_ff[61:0], 2'h0};
                    step_ff <= step_ff + 5'h1;
                    if (step_ff == rms_power_pkg::ROOT_LAST)
                    begin
                        state_ff <= rms_power_pkg::ST_STORE;
                    end
                end
                rms_power_pkg::ST_STORE:
                begin
                    ch_ff <= ch_ff + 4'h1;
                    state_ff <= (ch_ff == rms_power_pkg::CH_LAST) ?
                        rms_power_pkg::ST_IDLE : rms_power_pkg::ST_LOAD;
                end
                default:
                begin
                    state_ff <= rms_power_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    wire logic [2:0] widx = reg_addr[4:2];
    wire logic [1:0] pwidx = reg_addr[3:2];
    wire logic wr_rmsos = reg_wr && in_win(reg_addr, rms_power_pkg::A_RMSOS_BASE, 8'h8);
    wire logic wr_pgain = reg_wr && in_win(reg_addr, rms_power_pkg::A_PGAIN_BASE, 8'h3);
    wire logic wr_wattos = reg_wr && in_win(reg_addr, rms_power_pkg::A_WATTOS_BASE, 8'h3);
    wire logic clr_mm = reg_wr && (reg_addr == rms_power_pkg::A_STATUS) &&
        reg_wdata[rms_power_pkg::STAT_MISMATCH_BIT];
    wire logic nxt_mismatch = mm_event || (mismatch_ff && !clr_mm);
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        if (in_win(reg_addr, rms_power_pkg::A_RMS_BASE, 8'h8))
            rd_mux = rms_ff[widx];
        else if (in_win(reg_addr, rms_power_pkg::A_WATT_BASE, 8'h3))
            rd_mux = watt_ff[pwidx];
        else if (in_win(reg_addr, rms_power_pkg::A_RMSOS_BASE, 8'h8))
            rd_mux = rmsos_ff[widx];
        else if (in_win(reg_addr, rms_power_pkg::A_PGAIN_BASE, 8'h3))
            rd_mux = pgain_ff[pwidx];
        else if (in_win(reg_addr, rms_power_pkg::A_WATTOS_BASE, 8'h3))
            rd_mux = wattos_ff[pwidx];
        else if (reg_addr == rms_power_pkg::A_CFG)
            rd_mux = 32'(cfg_ff);
        else if (reg_addr == rms_power_pkg::A_STATUS)
            rd_mux = 32'(mismatch_ff);
        else if (reg_addr == rms_power_pkg::A_THR)
            rd_mux = thr_ff;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_ff <= rms_power_pkg::CFG_RST;
            thr_ff <= rms_power_pkg::WORD_RST;
            mismatch_ff <= 1'h0;
            above_ff <= 1'h0;
            mismatch_irq <= 1'h0;
            reg_rdata <= rms_power_pkg::WORD_RST;
        end
        else
        begin
            if (reg_wr && (reg_addr == rms_power_pkg::A_CFG))
                cfg_ff <= rms_power_pkg::cfg_t'(reg_wdata[3:0]);
            if (reg_wr && (reg_addr == rms_power_pkg::A_THR))
                thr_ff <= reg_wdata;
            if (mm_event)
                above_ff <= above_w;
            mismatch_ff <= nxt_mismatch;
            mismatch_irq <= nxt_mismatch && cfg_ff.mismatch_en;
            reg_rdata <= reg_rd ? rd_mux : rms_power_pkg::WORD_RST;
        end
    end

    generate
        for (genvar g = 0; g < 8; g++)
        begin : g_rms
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    rms_ff[g] <= rms_power_pkg::WORD_RST;
                    rmsos_ff[g] <= rms_power_pkg::WORD_RST;
                end
                else
                begin
                    if ((state_ff == rms_power_pkg::ST_STORE) && (ch_ff == 4'(g)))
                        rms_ff[g] <= root_ff;
                    if (wr_rmsos && (widx == 3'(g)))
                        rmsos_ff[g] <= reg_wdata;
                end
            end
        end
        for (genvar p = 0; p < 3; p++)
        begin : g_pwr
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    watt_ff[p] <= rms_power_pkg::WORD_RST;
                    pgain_ff[p] <= rms_power_pkg::WORD_RST;
                    wattos_ff[p] <= rms_power_pkg::WORD_RST;
                end
                else
                begin
                    if ((state_ff == rms_power_pkg::ST_STORE) && is_pwr && (pidx == 2'(p)))
                        watt_ff[p] <= watt_w[31:0];
                    if (wr_pgain && (pwidx == 2'(p)))
                        pgain_ff[p] <= reg_wdata;
                    if (wr_wattos && (pwidx == 2'(p)))
                        wattos_ff[p] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_root_exact: assert property (
        (state_ff == rms_power_pkg::ST_STORE) && !is_pwr |->
        (66'(root_ff) * 66'(root_ff) <= 66'(rad_in_ff)) &&
        ((66'(root_ff) + 66'h1) * (66'(root_ff) + 66'h1) > 66'(rad_in_ff)))
        else $error("square root result is not exact");
    chk_root_len: assert property (
        (state_ff == rms_power_pkg::ST_FILT2) && !is_pwr |=>
        (state_ff == rms_power_pkg::ST_ROOT) [*8] ##25 (state_ff == rms_power_pkg::ST_STORE))
        else $error("square root did not take 32 steps");
    chk_frame_done: assert property (
        (state_ff == rms_power_pkg::ST_IDLE) && sample_valid |->
        ##[1:600] (state_ff == rms_power_pkg::ST_IDLE))
        else $error("sample pass did not finish in time");
    chk_isum_sub: assert property (
        (cfg_ff.isum_cfg == rms_power_pkg::ISUM_SUB_N) |-> (isum_w == ia + ib + ic - in_n))
        else $error("current sum ignores subtract code");
    chk_pwr_bypass: assert property (
        (state_ff == rms_power_pkg::ST_FILT2) && bypass |=> (filt_ff == $past(prod_ff)))
        else $error("filter disable did not pass the product");
    chk_watt_store: assert property (
        (state_ff == rms_power_pkg::ST_STORE) && is_pwr |=>
        (watt_ff[$past(pidx)] == $past(watt_w[31:0])))
        else $error("active power result not stored");
    chk_flag_set: assert property (
        mm_event |=> mismatch_ff && (above_ff == $past(above_w)))
        else $error("mismatch change did not set the flag");
    chk_flag_hold: assert property (
        mismatch_ff && !clr_mm |=> mismatch_ff)
        else $error("mismatch flag dropped without a clear");
    chk_irq_follow: assert property (
        ##1 (mismatch_irq == (mismatch_ff && $past(cfg_ff.mismatch_en))))
        else $error("interrupt does not follow flag and enable");

    cov_full_pass: cover property ((state_ff == rms_power_pkg::ST_STORE) &&
        (ch_ff == rms_power_pkg::CH_LAST));
    cov_mismatch: cover property (mm_event);
    cov_bypass: cover property ((state_ff == rms_power_pkg::ST_FILT2) && bypass);
    cov_clear: cover property (mismatch_ff && clr_mm);

endmodule

`default_nettype wire

// [hw/rms_power_pkg.sv]
package rms_power_pkg;

    // ****************************************
    // Datapath shape
    // ****************************************
    localparam int unsigned MEM_AW = 5;
    localparam int unsigned MEM_DW = 64;
    localparam logic [3:0] CH_ISUM = 4'h7;
    localparam logic [3:0] CH_FIRST_PWR = 4'h8;
    localparam logic [3:0] CH_LAST = 4'ha;
    localparam int unsigned FILT_SHIFT = 9;
    localparam int unsigned OFFS_SHIFT = 15;
    localparam int unsigned WATT_SHIFT = 27;
    localparam int unsigned GAIN_SHIFT = 27;
    localparam logic [4:0] ROOT_LAST = 5'h1f;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] A_RMS_BASE = 8'h00;
    localparam logic [7:0] A_WATT_BASE = 8'h20;
    localparam logic [7:0] A_RMSOS_BASE = 8'h40;
    localparam logic [7:0] A_PGAIN_BASE = 8'h60;
    localparam logic [7:0] A_WATTOS_BASE = 8'h70;
    localparam logic [7:0] A_CFG = 8'h80;
    localparam logic [7:0] A_STATUS = 8'h84;
    localparam logic [7:0] A_THR = 8'h88;
    localparam int unsigned STAT_MISMATCH_BIT = 0;

    // ****************************************
    // Sum configuration codes
    // ****************************************
    localparam logic [1:0] ISUM_ADD_N = 2'h1;
    localparam logic [1:0] ISUM_SUB_N = 2'h2;

    // ****************************************
    // Types and reset values
    // ****************************************
    typedef struct packed {
        logic mismatch_en;
        logic power_filter_disable;
        logic [1:0] isum_cfg;
    } cfg_t;

    typedef struct packed {
        logic [2:0][31:0] cur;
        logic [31:0] neu;
        logic [2:0][31:0] volt;
    } samples_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOAD = 3'h1,
        ST_FILT1 = 3'h2,
        ST_FILT2 = 3'h3,
        ST_ROOT = 3'h4,
        ST_STORE = 3'h5
    } state_t;

    localparam cfg_t CFG_RST = 4'h0;
    localparam logic [31:0] WORD_RST = 32'h0;

endpackage

// [hw/rms_state_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module rms_state_mem (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [rms_power_pkg::MEM_AW-1:0] wr_addr,
    input wire logic [rms_power_pkg::MEM_DW-1:0] wr_data,
    // Read port, data one cycle after the address
    input wire logic [rms_power_pkg::MEM_AW-1:0] rd_addr,
    output logic [rms_power_pkg::MEM_DW-1:0] rd_data
);

    logic [rms_power_pkg::MEM_DW-1:0] mem_ff [2**rms_power_pkg::MEM_AW];

    // Cleared at reset so the filters start from rest instead of unknowns
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 2**rms_power_pkg::MEM_AW; i++)
            begin
                mem_ff[i] <= '0;
            end
            rd_data <= '0;
        end
        else
        begin
            if (wr_en)
            begin
                mem_ff[wr_addr] <= wr_data;
            end
            rd_data <= mem_ff[rd_addr];
        end
    end

endmodule

`default_nettype wire

// [verif/sample_source.sv]
`timescale 1ns/1ps
`default_nettype none

module sample_source (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request from the bench
    input wire logic send,
    input wire rms_power_pkg::samples_t send_data,
    // Stream to the block
    output logic sample_valid,
    output rms_power_pkg::samples_t samples
);
    rms_power_pkg::samples_t last_ff;

    // Off the valid cycle the bus shows the inverse of the last set,
    // so late sampling cannot pass by luck
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sample_valid <= 1'b0;
            samples <= '0;
            last_ff <= '0;
        end
        else if (send)
        begin
            sample_valid <= 1'b1;
            samples <= send_data;
            last_ff <= send_data;
        end
        else
        begin
            sample_valid <= 1'b0;
            samples <= ~last_ff;
        end
    end
endmodule

`default_nettype wire

// [verif/test_rms_power_calc.sv]
`timescale 1ns/1ps
`default_nettype none

module test_rms_power_calc;
    logic sys_clk;
    logic rst;
    logic send;
    rms_power_pkg::samples_t send_data;
    logic sample_valid;
    rms_power_pkg::samples_t samples;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic mismatch_irq;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    sample_source src (.sys_clk(sys_clk), .rst(rst), .send(send), .send_data(send_data),
        .sample_valid(sample_valid), .samples(samples));
    rms_power_calc uut (.sys_clk(sys_clk), .rst(rst), .sample_valid(sample_valid),
        .samples(samples), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mismatch_irq(mismatch_irq));

    // ****************************************
    // Bus and stream tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    task automatic run_pass(input rms_power_pkg::samples_t s);
        @(posedge sys_clk);
        send <= 1'b1;
        send_data <= s;
        @(posedge sys_clk);
        send <= 1'b0;
        // A pass is about 300 cycles; margin before results are read
        repeat (400) @(posedge sys_clk);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs;
        do_reset();
        reg_check("config", 8'h80, 32'h0);
        reg_check("status", 8'h84, 32'h0);
        reg_write(8'h80, 32'h0000000f);
        reg_check("config", 8'h80, 32'h0000000f);
        reg_write(8'h00, 32'h00001234);
        reg_check("rms read only", 8'h00, 32'h0);
        reg_write(8'h90, 32'h00005678);
        reg_check("unmapped", 8'h90, 32'h0);
        $display("test regs done");
    endtask

    // Zero input: result is the root of trim times 2^15 alone
    task automatic test_trim;
        rms_power_pkg::samples_t s;
        s = '0;
        do_reset();
        for (int k = 0; k < 8; k++)
            reg_write(8'h40 + 8'(4 * k), 32'(2 * (k + 1) * (k + 1)));
        run_pass(s);
        for (int k = 0; k < 8; k++)
            reg_check("rms trim", 8'(4 * k), 32'(256 * (k + 1)));
        reg_write(8'h40, 32'hffffff00);
        run_pass(s);
        reg_check("negative trim", 8'h00, 32'h0);
        $display("test trim done");
    endtask

    // One sample from zero state: x*x through two 2^-9 stages, root is x/512
    task automatic test_isum;
        rms_power_pkg::samples_t s;
        logic [31:0] exp_sum [4];
        exp_sum = '{32'd2048, 32'd4096, 32'd0, 32'd2048};
        s = '0;
        s.cur[0] = 32'hffe00000;
        s.cur[2] = 32'h00300000;
        s.neu = 32'h00100000;
        for (int c = 0; c < 4; c++)
        begin
            do_reset();
            reg_write(8'h80, 32'(c));
            reg_write(8'h4c, 32'd72);
            run_pass(s);
            reg_check("phase rms neg", 8'h00, 32'd4096);
            reg_check("phase rms", 8'h08, 32'd6144);
            reg_check("neutral rms", 8'h0c, 32'd2560);
            reg_check("sum rms", 8'h1c, exp_sum[c]);
        end
        $display("test isum done");
    endtask

    task automatic test_mismatch;
        rms_power_pkg::samples_t s;
        s = '0;
        do_reset();
        reg_write(8'h80, 32'h8);
        reg_write(8'h88, 32'd500);
        reg_write(8'h5c, 32'd8);
        run_pass(s);
        reg_check("flag rise", 8'h84, 32'h1);
        check("irq", 32'h1, {31'h0, mismatch_irq});
        reg_write(8'h84, 32'h1);
        reg_check("flag clear", 8'h84, 32'h0);
        check("irq off", 32'h0, {31'h0, mismatch_irq});
        run_pass(s);
        reg_check("flag steady", 8'h84, 32'h0);
        reg_write(8'h5c, 32'd2);
        run_pass(s);
        reg_check("flag fall", 8'h84, 32'h1);
        reg_write(8'h80, 32'h0);
        reg_check("flag held", 8'h84, 32'h1);
        check("irq masked", 32'h0, {31'h0, mismatch_irq});
        $display("test mismatch done");
    endtask

    // Raw product 2^40*(k+1) >> 27, half gain on top, then offset
    task automatic test_power;
        rms_power_pkg::samples_t s;
        s = '0;
        do_reset();
        for (int k = 0; k < 3; k++)
        begin
            s.cur[k] = 32'(k + 1) << 20;
            s.volt[k] = 32'h00100000;
            reg_write(8'h60 + 8'(4 * k), 32'h04000000);
            reg_write(8'h70 + 8'(4 * k), 32'(k + 5));
        end
        run_pass(s);
        // Filtered, one sample leaves the product far below 2^27
        for (int k = 0; k < 3; k++)
            reg_check("filtered power", 8'h20 + 8'(4 * k), 32'(k + 5));
        reg_write(8'h80, 32'h4);
        run_pass(s);
        for (int k = 0; k < 3; k++)
            reg_check("power", 8'h20 + 8'(4 * k), 32'(12288 * (k + 1) + k + 5));
        $display("test power done");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // About 4500 cycles expected; a hang ends the run well past that
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            $display("CHECK FAILED timeout expected done seen hang");
            print_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        send = 1'b0;
        send_data = '0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        test_regs();
        test_trim();
        test_isum();
        test_mismatch();
        test_power();
        print_verdict();
    end
endmodule

`default_nettype wire
